/* File: src/qafp_frame_port.sv */
`default_nettype none
// Overview of operation
// RULE1 - Chip select fall starts a conversion; chip select bounds each frame.
// RULE2 - Serial clock edges are the only conversion timebase.
// RULE3 - Conversion spans sixteen serial clock periods; host gives sixteen.
// RULE4 - Host keeps chip select high at least 50 ns between frames.
// RULE5 - Data input sampled on each falling serial clock edge; the code samples it only on the first twelve falling edges.
// RULE6 - Output bit changes on falling serial clock edge.
// RULE7 - Output undriven while deselected; driven only after chip select low.
// RULE8 - Output released after final falling edge of the frame.
// RULE9 - Frame: two zeros, two channel bits, result MSB first.
// RULE10 - Frame padded to 16 bits with trailing zeros per resolution.
// RULE11 - Channel picked from channel-select bits; sequencer bits kept.
// RULE12 - One input span for all channels, chosen by range bit.
// RULE13 - Coding bit 1 gives straight binary, 0 twos complement.
// RULE14 - Host allows up to 1 us power-up before trusting results.
// RULE15 - Only first twelve captured bits reach configuration.
// RULE16 - Configuration updated from next eleven bits only if first is 1.
// RULE17 - Range 1 means zero to reference, 0 zero to twice.
// RULE18 - Analog sample taken at chip select falling edge.
module qafp_frame_port #(
  parameter int unsigned RES_BITS = qafp_pkg::RES_BITS_12
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  input  wire logic [11:0] i_sample_code,
  output logic             o_dout,
  output logic             o_dout_oe,
  output logic             o_sample_strobe,
  output logic             o_conv_busy,
  output logic      [1:0]  o_chan_sel,
  output logic      [1:0]  o_seq_ctl,
  output logic      [1:0]  o_pwr_mode,
  output logic             o_range_single_ref,
  output logic             o_coding_binary
);
  // ------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_d;
  logic       cs_n_d;
  qafp_sync #(.W(3)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_sclk, i_cs_n, i_din}),
    .o_sync     (pins_s)
  );
  wire sclk_s   = pins_s[2];
  wire cs_n_s   = pins_s[1];
  wire din_s    = pins_s[0];
  wire sclk_fall = sclk_d & ~sclk_s;
  wire cs_fall   = cs_n_d & ~cs_n_s;
  wire cs_rise   = ~cs_n_d & cs_n_s;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  // ------------------------------------------------------------
  // Frame state and counters
  // ------------------------------------------------------------
  qafp_pkg::qafp_state_t state;
  qafp_pkg::qafp_state_t next_state;
  logic [4:0]  fall_cnt;
  logic [15:0] shift_out;
  logic [11:0] cfg_shift;
  logic [10:0] cfg;
  logic [11:0] held_code;

  wire last_fall  = sclk_fall & (fall_cnt == qafp_pkg::CNT_LAST - 5'h01);
  wire cfg_capture = sclk_fall & (fall_cnt < qafp_pkg::CNT_CFG_LAST);
  wire cfg_commit = sclk_fall
                  & (fall_cnt == qafp_pkg::CNT_CFG_LAST - 5'h01);
  wire [11:0] cfg_word = {cfg_shift[10:0], din_s};

  // Next state: chip select rising aborts a frame at any point
  always_comb begin
    next_state = state;
    unique case (state)
      qafp_pkg::QAFP_IDLE:
        if (cs_fall) next_state = qafp_pkg::QAFP_FRAME; // RULE1
      qafp_pkg::QAFP_FRAME:
        if (cs_rise) next_state = qafp_pkg::QAFP_IDLE;
        else if (last_fall) next_state = qafp_pkg::QAFP_DONE; // RULE3
      qafp_pkg::QAFP_DONE:
        if (cs_rise) next_state = qafp_pkg::QAFP_IDLE;
      default: next_state = qafp_pkg::QAFP_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) state <= qafp_pkg::QAFP_IDLE;
    else       state <= next_state;
  end

  // Falling-edge counter; serial clock is the conversion timebase
  always_ff @(posedge i_core_clk) begin
    if (i_rst || cs_fall) fall_cnt <= 5'h00;
    else if (state == qafp_pkg::QAFP_FRAME && sclk_fall)
      fall_cnt <= fall_cnt + 5'h01; // RULE2
  end

  // ------------------------------------------------------------
  // Result formatting
  // ------------------------------------------------------------
  // Analog code arrives straight binary; twos complement flips MSB
  wire [11:0] coded = cfg[qafp_pkg::CFG_CODING_POS] ? held_code
                    : {~held_code[11], held_code[10:0]}; // RULE13
  // Truncate to the variant resolution, zero pad to 16 bits
  wire [11:0] res_mask = ~(12'hfff >> RES_BITS);
  wire [15:0] frame_word = {2'b00, cfg[7:6],
                            coded & res_mask}; // RULE9 RULE10

  // Sample taken as chip select falls; frame uses that code
  always_ff @(posedge i_core_clk) begin
    if (i_rst) held_code <= 12'h000;
    else if (cs_fall) held_code <= i_sample_code; // RULE18
  end

  // ------------------------------------------------------------
  // Output shifter and drive enable
  // ------------------------------------------------------------
  // First bit is presented at chip select fall, then each falling edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      shift_out <= 16'h0000;
    end else if (state == qafp_pkg::QAFP_FRAME && fall_cnt == 5'h00
                 && !sclk_fall && !cs_rise) begin
      shift_out <= frame_word;
    end else if (state == qafp_pkg::QAFP_FRAME && sclk_fall) begin
      shift_out <= {shift_out[14:0], 1'b0}; // RULE6
    end
  end

  // Frame loads one cycle after cs_fall, so coded uses held_code
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dout    <= 1'b0;
      o_dout_oe <= 1'b0;
    end else begin
      o_dout    <= shift_out[15];
      o_dout_oe <= (state == qafp_pkg::QAFP_FRAME)
                 & ~cs_rise & ~last_fall; // RULE7 RULE8
    end
  end

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) cfg_shift <= 12'h000;
    else if (state == qafp_pkg::QAFP_FRAME && cfg_capture)
      cfg_shift <= cfg_word; // RULE5 RULE15
  end

  // Commit only on the twelfth edge; later bits never reach cfg
  always_ff @(posedge i_core_clk) begin
    if (i_rst) cfg <= qafp_pkg::CFG_RESET;
    else if (state == qafp_pkg::QAFP_FRAME && cfg_commit
             && cfg_word[qafp_pkg::CFG_WRITE_POS])
      cfg <= cfg_word[10:0]; // RULE16
  end

  // ------------------------------------------------------------
  // Status and configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_sample_strobe    <= 1'b0;
      o_conv_busy        <= 1'b0;
      o_chan_sel         <= 2'b00;
      o_seq_ctl          <= 2'b00;
      o_pwr_mode         <= 2'b00;
      o_range_single_ref <= 1'b0;
      o_coding_binary    <= 1'b0;
    end else begin
      o_sample_strobe    <= cs_fall; // RULE18
      o_conv_busy        <= (next_state == qafp_pkg::QAFP_FRAME);
      o_chan_sel         <= cfg[7:6]; // RULE11
      o_seq_ctl          <= {cfg[qafp_pkg::CFG_SEQ_HI_POS],
                             cfg[qafp_pkg::CFG_SEQ_LO_POS]}; // RULE11
      o_pwr_mode         <= cfg[5:4];
      o_range_single_ref <= cfg[qafp_pkg::CFG_RANGE_POS]; // RULE12 RULE17
      o_coding_binary    <= cfg[qafp_pkg::CFG_CODING_POS];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_frame_end;
    state == qafp_pkg::QAFP_FRAME && last_fall;
  endsequence

  sequence s_release;
    ##1 !o_dout_oe;
  endsequence

  oe_idle_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $past(state) == qafp_pkg::QAFP_IDLE |-> !o_dout_oe) // RULE7
    else $error("data output driven while deselected");

  oe_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_frame_end |-> s_release) // RULE8
    else $error("data output not released after last edge");

  busy_start_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state == qafp_pkg::QAFP_IDLE && cs_fall |=> o_conv_busy) // RULE1
    else $error("conversion did not start on select fall");

  cfg_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cfg_commit && !cfg_word[11] |=> $stable(cfg)) // RULE16
    else $error("configuration changed with write bit low");

  cfg_late_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sclk_fall && fall_cnt >= qafp_pkg::CNT_CFG_LAST
    |=> $stable(cfg)) // RULE15
    else $error("late bit altered configuration");

  shift_edge_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state == qafp_pkg::QAFP_FRAME && fall_cnt != 5'h00 && !sclk_fall
    |=> $stable(shift_out)) // RULE6
    else $error("output bit changed off a falling edge");

  lead_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    frame_word[15:14] == 2'b00 && frame_word[13:12] == cfg[7:6]) // RULE9
    else $error("frame header wrong");

  pad_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (frame_word[11:0] & ~res_mask) == 12'h000) // RULE10
    else $error("frame padding not zero");

  strobe_sample_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cs_fall |=> o_sample_strobe
    && held_code == $past(i_sample_code)) // RULE18
    else $error("sample not captured on select fall");

  count_cap_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    fall_cnt <= qafp_pkg::CNT_LAST) // RULE3
    else $error("edge count passed sixteen");
endmodule
`default_nettype wire

/* File: pkg/qafp_pkg.sv */
`default_nettype none
package qafp_pkg;
  // Frame geometry
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CFG_BITS      = 12;
  localparam int unsigned CFG_LOAD_BITS = 11;
  localparam logic [4:0]  CNT_LAST      = 5'h10;
  localparam logic [4:0]  CNT_CFG_LAST  = 5'h0c;
  // Configuration word field positions (first bit in is bit 11)
  localparam int unsigned CFG_WRITE_POS  = 11;
  localparam int unsigned CFG_SEQ_HI_POS = 10;
  localparam int unsigned CFG_CHAN_HI_POS = 7;
  localparam int unsigned CFG_CHAN_LO_POS = 6;
  localparam int unsigned CFG_PM_HI_POS  = 5;
  localparam int unsigned CFG_PM_LO_POS  = 4;
  localparam int unsigned CFG_SEQ_LO_POS = 3;
  localparam int unsigned CFG_RANGE_POS  = 1;
  localparam int unsigned CFG_CODING_POS = 0;
  // Reset values
  localparam logic [10:0] CFG_RESET     = 11'h000;
  // Result resolutions of the variants
  localparam int unsigned RES_BITS_8    = 8;
  localparam int unsigned RES_BITS_10   = 10;
  localparam int unsigned RES_BITS_12   = 12;
  // Timing, informational to the host
  localparam int unsigned QUIET_NS      = 50;
  localparam int unsigned POWERUP_NS    = 1000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned QUIET_CYC     =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    QAFP_IDLE  = 3'b001,
    QAFP_FRAME = 3'b010,
    QAFP_DONE  = 3'b100
  } qafp_state_t;
endpackage
`default_nettype wire

/* File: src/qafp_sync.sv */
`default_nettype none
module qafp_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;
  // -----------------------------------------------
  // Two-stage synchroniser, one per bit
  // -----------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk) begin
        // Reset to the idle level of the pins, so no false edge follows
        if (i_rst) begin
          meta[g]   <= 1'b1;
          o_sync[g] <= 1'b1;
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: sim/qafp_host.sv */
`default_nettype none
// ----------------------------------------
// Host controller on the far side of the port
// ----------------------------------------
module qafp_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_dout,
  input  wire logic        i_dout_oe,
  output logic             o_sclk,
  output logic             o_cs_n,
  output logic             o_din,
  output logic      [15:0] o_rx,
  output logic             o_oe_tail
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last;
  // Idle: deselected, serial clock parked high
  initial begin
    o_sclk    = 1'b1;
    o_cs_n    = 1'b1;
    o_din     = 1'b0;
    o_rx      = 16'h0000;
    o_oe_tail = 1'b0;
    last      = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // One frame; 13 high plus 12 low cycles make a 125 ns serial clock
  task automatic frame(input logic [15:0] word, input int nfall);
    step(1);
    o_cs_n <= 1'b0;
    step(13);
    for (int k = 0; k < nfall; k++) begin
      o_din <= word[15-k];
      step(6);
      // A released line reads as the previous bit inverted, so it never repeats that bit
      last = i_dout_oe ? i_dout : ~last;
      o_rx <= {o_rx[14:0], last};
      o_sclk <= 1'b0;
      step(12);
      o_sclk <= 1'b1;
      step(7);
    end
    o_din <= ~o_din;
    o_oe_tail <= i_dout_oe;
    o_cs_n <= 1'b1;
    // Gap also covers the power-up allowance after any power mode
    step(qafp_pkg::POWERUP_NS / qafp_pkg::CLK_PERIOD_NS);
  endtask
endmodule
`default_nettype wire

/* File: sim/qafp_frame_port_bench.sv */
`default_nettype none
// ----------------------------------------
// Bench for the serial frame port
// ----------------------------------------
module qafp_frame_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_core_clk, i_rst, sclk, cs_n, din, dout, dout_oe;
  logic        strobe, busy, range_ref, coding, oe_tail;
  logic [11:0] code;
  logic [1:0]  chan, seq, pwr;
  logic [15:0] rx;
  int          mismatches, tests_run, strobes;

  qafp_frame_port dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .i_sample_code(code),
    .o_dout(dout), .o_dout_oe(dout_oe), .o_sample_strobe(strobe),
    .o_conv_busy(busy), .o_chan_sel(chan), .o_seq_ctl(seq),
    .o_pwr_mode(pwr), .o_range_single_ref(range_ref),
    .o_coding_binary(coding));
  qafp_host host_u (.i_core_clk(i_core_clk), .i_dout(dout),
    .i_dout_oe(dout_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .o_rx(rx), .o_oe_tail(oe_tail));

  // Core clock, 5 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // Sample pulses counted, one expected per frame
  always @(posedge i_core_clk) begin
    if (strobe === 1'b1) strobes++;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Configuration outputs packed as chan, seq, power, range, coding
  task automatic check_cfg(input logic [7:0] exp);
    check("cfg", {8'h00, chan, seq, pwr, range_ref, coding},
          {8'h00, exp});
  endtask
  // Shared frame: idle, busy and strobe judged around the host
  task automatic run_frame(input logic [15:0] word, input int nfall,
                           input logic [11:0] smp);
    int s0;
    s0 = strobes;
    code <= smp;
    @(negedge i_core_clk);
    check("oe idle", {15'h0, dout_oe}, 16'h0000);
    fork
      host_u.frame(word, nfall);
      begin
        repeat (40) @(negedge i_core_clk);
        check("busy", {15'h0, busy}, 16'h0001);
      end
    join
    @(negedge i_core_clk);
    check("strobes", 16'(strobes - s0), 16'h0001);
    if (nfall == 16) check("oe tail", {15'h0, oe_tail}, 16'h0000);
    @(posedge i_core_clk);
  endtask

  // Write frame; trailing ones must not reach the configuration
  task automatic test_write;
    run_frame(16'hcb3f, 16, 12'habc);
    check("frame twos", rx, 16'h02bc);
    check_cfg(8'haf);
  endtask
  // First bit 0 leaves configuration alone
  task automatic test_hold;
    run_frame(16'h7fff, 16, 12'h5a3);
    check("frame binary", rx, 16'h25a3);
    check_cfg(8'haf);
  endtask
  // New settings apply to the next conversion only
  task automatic test_rewrite;
    run_frame(16'h8c80, 16, 12'h0ff);
    check("frame old cfg", rx, 16'h20ff);
    check_cfg(8'hd0);
  endtask
  // Frame cut after 8 edges commits nothing
  task automatic test_abort;
    run_frame(16'hffff, 8, 12'h123);
    check_cfg(8'hd0);
    run_frame(16'h7fff, 16, 12'h801);
    check("frame after cut", rx, 16'h3001);
  endtask

  // Watchdog well beyond the five frames
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    finish_test();
  end
  // Main sequence
  initial begin
    i_rst = 1'b1;
    code = 12'h000;
    mismatches = 0;
    tests_run = 0;
    strobes = 0;
    repeat (19) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("reset outs", {dout, dout_oe, strobe, busy, chan, seq, pwr,
          range_ref, coding}, 16'h0000);
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    test_write();
    test_hold();
    test_rewrite();
    test_abort();
    finish_test();
  end
endmodule
`default_nettype wire
